//--- hdl/host_port_regs.vh
// Constants for the host parallel slave port.
// Assumes inclusion by the port module only.
`ifndef HOST_PORT_REGS_VH
`define HOST_PORT_REGS_VH

// Mode select levels
`define MODE_CTRL        1'b0
`define MODE_FAST        1'b1
// Type select levels in control mode
`define TYPE_DATA        1'b0
`define TYPE_ALT         1'b1
// Reset values
`define BYTE_RESET       8'h00
`define WORD_RESET       16'h0000
`define ONES_BYTE        8'hFF
`define SYNC_IDLE        2'h3
// Access kinds handed to the core side
`define KIND_DATA        2'h0
`define KIND_CTRL        2'h1
`define KIND_FAST        2'h2
// Write buffer fill levels
`define BUF_EMPTY        2'h0
`define BUF_DEPTH        2'h2

`endif

//--- hdl/host_parallel_slave_port.v
// Host parallel slave port: asynchronous 8/16-bit host strobes sampled
// on the system clock, write words buffered toward the core.
// Assumes host pins arrive raw; the board resolves data lines from enables.
`timescale 1ns/1ps
`include "host_port_regs.vh"

// Functional notes
// R1 - Drive low data byte only while select and read strobe are low.
// R2 - Data lines are inputs while select and write strobe are low.
// R3 - Capture write data at write strobe rise with select low.
// R4 - Present read data once read strobe falls with select low.
// R5 - Decode access kind from mode and type selects with strobes.
// R6 - Control mode: type picks data or status, data or control.
// R7 - Fast mode ignores type select; every access is data.
// R8 - Control mode: raise request while data waits for host.
// R9 - Host read with select and read low clears the request.
// R10 - Select active low; strobes ignored while select high.
// R11 - Mode select low is control mode, high is fast mode.
// R12 - High byte carries data only in fast mode.
// R13 - Fast mode: done flag shows current transfer completion.
// R14 - Synchronise host strobes before edge detection, one action each.
module host_parallel_slave_port (
    // System
    input  wire        clk_sys,
    input  wire        rst_b,
    // Host control pins
    input  wire        host_cs_b,
    input  wire        host_rd_b,
    input  wire        host_wr_b,
    input  wire        transfer_type_select,
    input  wire        transfer_mode_select,
    // Host data pins, split three ways
    input  wire [7:0]  host_bus_low_byte_in,
    output reg  [7:0]  host_bus_low_byte_out,
    output wire        host_bus_low_byte_oe_b,
    input  wire [7:0]  host_bus_high_byte_in,
    output reg  [7:0]  host_bus_high_byte_out,
    output wire        host_bus_high_byte_oe_b,
    // Host status pins
    output reg         host_irq,
    output wire        transfer_done_flag,
    // Core side: words written by the host
    output wire        wr_valid,
    input  wire        wr_ready,
    output wire [15:0] wr_data,
    output wire [1:0]  wr_kind,
    // Core side: words to be read by the host
    input  wire        rd_valid,
    output wire        rd_ready,
    input  wire [15:0] rd_data,
    input  wire [7:0]  status_byte
);

// =============================================
// Pin synchronisers
reg [1:0] cs_q;
reg [1:0] rd_q;
reg [1:0] wr_q;
reg [1:0] mode_q;
reg [1:0] type_q;
reg [7:0] dlo_s1_q;
reg [7:0] dlo_q;
reg [7:0] dhi_s1_q;
reg [7:0] dhi_q;
reg       rd_act_q;
reg       wr_act_q;

// Only the second stage is read by logic
wire cs_b   = cs_q[1];
wire mode_s = mode_q[1];
wire type_s = type_q[1];
// R10 select gating
wire rd_act = ~cs_b & ~rd_q[1];
wire wr_act = ~cs_b & ~wr_q[1];
// R14 single edge events
wire rd_fall = rd_act & ~rd_act_q;
wire rd_end  = ~rd_act & rd_act_q;
// R3 capture at write rise
wire wr_rise = ~wr_act & wr_act_q & ~cs_b;

// R14 two-stage sampling
always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
        cs_q     <= `SYNC_IDLE;
        rd_q     <= `SYNC_IDLE;
        wr_q     <= `SYNC_IDLE;
        mode_q   <= {2{`MODE_CTRL}};
        type_q   <= {2{`TYPE_DATA}};
        dlo_s1_q <= `BYTE_RESET;
        dlo_q    <= `BYTE_RESET;
        dhi_s1_q <= `BYTE_RESET;
        dhi_q    <= `BYTE_RESET;
        rd_act_q <= 1'b0;
        wr_act_q <= 1'b0;
    end else begin
        cs_q     <= {cs_q[0], host_cs_b};
        rd_q     <= {rd_q[0], host_rd_b};
        wr_q     <= {wr_q[0], host_wr_b};
        mode_q   <= {mode_q[0], transfer_mode_select};
        type_q   <= {type_q[0], transfer_type_select};
        dlo_s1_q <= host_bus_low_byte_in;
        dlo_q    <= dlo_s1_q;
        dhi_s1_q <= host_bus_high_byte_in;
        dhi_q    <= dhi_s1_q;
        rd_act_q <= rd_act;
        wr_act_q <= wr_act;
    end
end

// =============================================
// Access decode
function [1:0] kind_of;
    input mode;
    input typ;
    begin
        // R11 mode level picks mode
        // R7 fast mode ignores type
        if (mode == `MODE_FAST)
            kind_of = `KIND_FAST;
        // R6 control mode type choice
        else if (typ == `TYPE_DATA)
            kind_of = `KIND_DATA;
        else
            kind_of = `KIND_CTRL;
    end
endfunction

// R5 kind latched with strobe
wire [1:0] cur_kind = kind_of(mode_s, type_s);

// =============================================
// Two-entry write buffer
reg [15:0] buf_data_q [0:1];
reg [1:0]  buf_kind_q [0:1];
reg [15:0] wdat_q;
reg        wptr_q;
reg        rptr_q;
reg [1:0]  count_q;

wire buf_full  = (count_q == `BUF_DEPTH);
wire buf_push  = wr_rise & ~buf_full;
wire buf_pop   = wr_valid & wr_ready;
// Push that takes the last free entry
wire buf_fill  = buf_push & ~buf_pop & (count_q != `BUF_EMPTY);

assign wr_valid = (count_q != `BUF_EMPTY);
assign wr_data  = buf_data_q[rptr_q];
assign wr_kind  = buf_kind_q[rptr_q];

always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
        buf_data_q[0] <= `WORD_RESET;
        buf_data_q[1] <= `WORD_RESET;
        buf_kind_q[0] <= `KIND_DATA;
        buf_kind_q[1] <= `KIND_DATA;
        wptr_q        <= 1'b0;
        rptr_q        <= 1'b0;
        count_q       <= `BUF_EMPTY;
        wdat_q        <= `WORD_RESET;
    end else begin
        // R3 last word seen with strobe low
        if (wr_act)
            wdat_q <= {dhi_q, dlo_q};
        if (buf_push) begin
            // R12 high byte only in fast mode
            buf_data_q[wptr_q] <= {(mode_s ? wdat_q[15:8] : `BYTE_RESET),
                                   wdat_q[7:0]};
            buf_kind_q[wptr_q] <= cur_kind;
            wptr_q             <= ~wptr_q;
        end
        if (buf_pop)
            rptr_q <= ~rptr_q;
        count_q <= count_q + {1'b0, buf_push} - {1'b0, buf_pop};
    end
end

// =============================================
// Read path, request and ready flags
reg rd_is_data_q;
reg done_q;

// Core word consumed at end of a data read
assign rd_ready = rd_end & rd_is_data_q & rd_valid;

always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
        host_bus_low_byte_out  <= `BYTE_RESET;
        host_bus_high_byte_out <= `BYTE_RESET;
        rd_is_data_q           <= 1'b0;
        host_irq               <= 1'b0;
        done_q                 <= 1'b1;
    end else begin
        // R4 present data on read fall
        if (rd_fall) begin
            rd_is_data_q <= (cur_kind != `KIND_CTRL);
            if (cur_kind == `KIND_CTRL) begin
                // R6 status on alternate read
                host_bus_low_byte_out  <= status_byte;
                host_bus_high_byte_out <= `BYTE_RESET;
            end else begin
                host_bus_low_byte_out  <= rd_data[7:0];
                host_bus_high_byte_out <= rd_data[15:8];
            end
        end
        // R9 read clears, R8 pending data sets
        if (mode_s == `MODE_CTRL && rd_valid && !rd_act)
            host_irq <= 1'b1;
        else if (rd_fall || mode_s == `MODE_FAST)
            host_irq <= 1'b0;
        // R13 busy during access, ready once taken
        if (rd_fall || wr_act || buf_full || buf_fill)
            done_q <= 1'b0;
        else if (!rd_act)
            done_q <= 1'b1;
    end
end

// R13 flag shown in fast mode
assign transfer_done_flag = done_q | ~mode_s;

// R1 drive only on active read, R2 input otherwise
assign host_bus_low_byte_oe_b  = ~(~host_cs_b & ~host_rd_b);
// R12 high byte driven in fast mode only
assign host_bus_high_byte_oe_b = ~(~host_cs_b & ~host_rd_b & mode_s);

endmodule // host_parallel_slave_port

//--- bench/host_port_properties.sv
// Checker for the host parallel slave port.
// Bound onto the port module; sees only its ports.
`timescale 1ns/1ps
module host_port_properties (
    // Clock and reset
    input wire clk_sys,
    input wire rst_b,
    // Host pins
    input wire host_cs_b,
    input wire host_rd_b,
    input wire transfer_mode_select,
    // Core side
    input wire rd_valid,
    input wire rd_ready,
    input wire wr_valid,
    // Device outputs
    input wire host_bus_low_byte_oe_b,
    input wire host_bus_high_byte_oe_b,
    input wire host_irq,
    input wire transfer_done_flag
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    sequence s_read_held;
        (!host_cs_b && !host_rd_b) [*4];
    endsequence
    a_low_drive: assert property (host_bus_low_byte_oe_b ==
        (host_cs_b | host_rd_b)) else $error("low drive wrong");
    a_high_fast: assert property (!host_bus_high_byte_oe_b |->
        transfer_mode_select && !host_bus_low_byte_oe_b) else $error("hi");
    a_irq_clear: assert property (s_read_held |-> !host_irq)
        else $error("irq not cleared");
    a_irq_cause: assert property ($rose(host_irq) |-> $past(rd_valid))
        else $error("irq without data");
    a_done_ctrl: assert property ((!transfer_mode_select) [*4] |->
        transfer_done_flag) else $error("done low in control mode");
    a_rd_pulse: assert property (rd_ready |=> !rd_ready)
        else $error("rd_ready too long");
    a_rd_cause: assert property (rd_ready |-> rd_valid && host_rd_b &&
        $past(host_rd_b, 2)) else $error("rd_ready early");
    a_cs_gate: assert property (host_cs_b [*8] |->
        !rd_ready && !$rose(wr_valid)) else $error("access without cs");
endmodule // host_port_properties

bind host_parallel_slave_port host_port_properties u_props (.*);

//--- bench/host_model.sv
// Host processor model for the parallel port pins.
// Shares the system clock; resolves the data lines.
`timescale 1ns/1ps
module host_model (
    // Clock and device outputs
    input  wire       clk_sys,
    input  wire       transfer_done_flag,
    input  wire       host_bus_low_byte_oe_b,
    input  wire       host_bus_high_byte_oe_b,
    input  wire [7:0] host_bus_low_byte_out,
    input  wire [7:0] host_bus_high_byte_out,
    // Host strobes and selects
    output reg        host_cs_b            = 1'h1,
    output reg        host_rd_b            = 1'h1,
    output reg        host_wr_b            = 1'h1,
    output reg        transfer_type_select = 1'h0,
    output reg        transfer_mode_select = 1'h0,
    // Resolved data lines
    output wire [7:0] host_bus_low_byte_in,
    output wire [7:0] host_bus_high_byte_in
);
    reg [15:0] dq = 16'h0000;
    assign host_bus_low_byte_in = host_bus_low_byte_oe_b ? dq[7:0] :
        host_bus_low_byte_out;
    assign host_bus_high_byte_in = host_bus_high_byte_oe_b ? dq[15:8] :
        host_bus_high_byte_out;
    task acc(input m, t, w, input [15:0] d, output [15:0] q);
        integer i;
        begin
            transfer_mode_select <= m;
            transfer_type_select <= t;
            dq <= d;
            for (i = 0; i < 30 && m && !transfer_done_flag; i = i + 1)
                @(posedge clk_sys);
            repeat (3) @(posedge clk_sys);
            host_cs_b <= 1'h0;
            host_rd_b <= w;
            host_wr_b <= !w;
            repeat (5) @(posedge clk_sys);
            q = {host_bus_high_byte_in, host_bus_low_byte_in};
            host_rd_b <= 1'h1;
            host_wr_b <= 1'h1;
            // select held past the strobe edge
            repeat (3) @(posedge clk_sys);
            host_cs_b <= 1'h1;
            repeat (4) @(posedge clk_sys);
            dq <= ~d;
        end
    endtask
    task set_mode(input m);
        begin
            @(posedge clk_sys);
            transfer_mode_select <= m;
            repeat (3) @(posedge clk_sys);
        end
    endtask
endmodule // host_model

//--- bench/host_parallel_slave_port_test.sv
// Bench for the host parallel slave port.
// Host pins come from host_model; core side driven here.
`timescale 1ns/1ps
module host_parallel_slave_port_test;
    reg clk_sys = 1'h0, rst_b = 1'h0, wr_ready = 1'h0, rd_valid = 1'h0;
    reg [15:0] rd_data = 16'h0000, q;
    reg [7:0] status_byte = 8'h00;
    wire host_cs_b, host_rd_b, host_wr_b, transfer_type_select, rd_ready;
    wire transfer_mode_select, host_bus_low_byte_oe_b, host_irq, wr_valid;
    wire host_bus_high_byte_oe_b, transfer_done_flag;
    wire [7:0] host_bus_low_byte_in, host_bus_low_byte_out;
    wire [7:0] host_bus_high_byte_in, host_bus_high_byte_out;
    wire [15:0] wr_data;
    wire [1:0] wr_kind;
    integer bad_count = 0, n_tests = 0;
    reg [18:0] rd_seen = 19'h0;
    host_model host (.*);
    host_parallel_slave_port dut (.*);
    initial forever #50 clk_sys = ~clk_sys;
    // Core words consumed by data reads
    always @(posedge clk_sys)
        if (rd_ready) rd_seen <= rd_seen + 19'h1;
    task chk(input [31:0] nm, input [18:0] s, e);
        begin
            n_tests = n_tests + 1;
            if (s !== e) begin
                bad_count = bad_count + 1;
                $display("BAD %s exp %h got %h", nm, e, s);
            end
        end
    endtask
    task test_done;
        begin
            $display("checks %0d bad %0d", n_tests, bad_count);
            if (bad_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
            else $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    task pop(input [15:0] e, input [1:0] k);
        begin
            @(negedge clk_sys);
            chk("word", {wr_valid, wr_kind, wr_data}, {1'h1, k, e});
            @(posedge clk_sys) wr_ready <= 1'h1;
            @(posedge clk_sys) wr_ready <= 1'h0;
        end
    endtask
    task t_ctrl_write;
        begin
            host.acc(1'h0, 1'h0, 1'h1, 16'h5AA5, q);
            pop(16'h00A5, 2'h0);
            host.acc(1'h0, 1'h1, 1'h1, 16'h5AA5, q);
            pop(16'h00A5, 2'h1);
        end
    endtask
    task t_fast_fill;
        begin
            host.acc(1'h1, 1'h0, 1'h1, 16'h1234, q);
            host.acc(1'h1, 1'h1, 1'h1, 16'hBEEF, q);
            host.acc(1'h1, 1'h0, 1'h1, 16'hCAFE, q);
            @(negedge clk_sys);
            chk("full", {18'h0, transfer_done_flag}, 19'h0);
            pop(16'h1234, 2'h2);
            pop(16'hBEEF, 2'h2);
            @(negedge clk_sys);
            chk("drop", {wr_valid, 18'h0}, 19'h0);
            chk("free", {18'h0, transfer_done_flag}, 19'h1);
        end
    endtask
    task t_reads;
        begin
            host.set_mode(1'h0);
            @(posedge clk_sys);
            rd_data <= 16'hBEEF;
            status_byte <= 8'h3C;
            rd_valid <= 1'h1;
            repeat (4) @(negedge clk_sys);
            chk("irq", {18'h0, host_irq}, 19'h1);
            @(posedge clk_sys);
            host.acc(1'h0, 1'h1, 1'h0, 16'h0000, q);
            chk("stat", {11'h0, q[7:0]}, 19'h3C);
            host.acc(1'h0, 1'h0, 1'h0, 16'h0000, q);
            chk("rdlo", {11'h0, q[7:0]}, 19'hEF);
            host.acc(1'h1, 1'h1, 1'h0, 16'h0000, q);
            chk("rd16", {3'h0, q}, 19'hBEEF);
            chk("rdrq", rd_seen, 19'h2);
        end
    endtask
    initial begin
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'h1;
        t_ctrl_write;
        t_fast_fill;
        t_reads;
        test_done;
    end
    initial begin
        #400000;
        bad_count = bad_count + 1;
        test_done;
    end
endmodule // host_parallel_slave_port_test
